// ==== hdl/mmci_top.sv ====
// Mailbox command interpreter of the modem engine, with its transmit FIFO.
// Assumes a host on the byte-wide mailbox pins (asynchronous, synchronised
// here) and a signal path, memory and front end on the same 20 MHz clock.
// Summary of operation
// R1: Reset-defaults opcode restores all parameters but front-end config and tone select, then idles awaiting commands.
// R2: Idle opcode changes nothing; running multi-baud work continues.
// R3: Retrain opcode starts the retrain sequence toward the far modem.
// R4: Set-gain opcode loads gain from bytes 1-2 for transmit scaling.
// R5: Transmit opcode sends byte 1 LSB first; byte 2 ignored.
// R6: Transmit-more sends data and takes next command at next baud.
// R7: Store opcodes write 16-bit word at pointer; counting one increments it.
// R8: Pointer-read loads pointer from bytes 1-2 and returns addressed word.
// R9: Pair read returns upper bytes of word and next word; pointer kept.
// R10: Three configuration opcodes latch parameters from bytes 1 and 2.
// R11: Front-end config forwards both bytes unchanged to the front end.
// R12: Front-end reads return 12-bit register; writes load transmit registers.
// R13: Tone-select programs the tone generators without enabling them.
// R14: Define-tone loads generator one or two phase increment, not enabled.
// R15: Silence disables both tone generators.
// R16: Tone-enable sets each generator; both on boosts tone two 2dB.
// R17: Engine posts three-byte response when owning mailbox; data beats answer.
// R18: Status byte 0 holds four flags, two info-type bits, H and 107.
// R19: Info-type bits select answer, data, data plus status, or status only.
// R20: Handshake reports rate sequence in byte 1 and training events in byte 2.
// R21: Call phase: flags zero/one band energy, flag two answer tone.
// R22: Handshake: flag zero quality, one timeout, both on illegal rate sequence.
// R23: Acknowledge read drops request within 800ns; register-select-high read ends.
// R24: Handshake bit stays 1 for the whole handshake, cleared on success.
// R25: Data phase: flags zero/one quality code; 11 means remote retrain.
// R26: Unknown opcodes behave as the idle command.
`include "mmci_cfg.svh"

// ----------------------------------------------------------------------------
// Transmit FIFO
// ----------------------------------------------------------------------------
module mmci_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset_n,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } mmci_fifo_t;
  mmci_fifo_t r_reg, r_next;
  logic push, pop;

  // Honest full and empty from the fill count
  assign o_in_ready  = (r_reg.cnt != (AW+1)'(D));
  assign o_out_valid = (r_reg.cnt != '0);
  assign o_out_data  = r_reg.mem[r_reg.rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Pointer and count update
  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wp] = i_in_data;
      r_next.wp = (r_reg.wp == AW'(D-1)) ? '0 : r_reg.wp + 1'b1;
    end
    if (pop) r_next.rp = (r_reg.rp == AW'(D-1)) ? '0 : r_reg.rp + 1'b1;
    r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) r_reg <= '0;
    else r_reg <= r_next;
  end
endmodule

// ----------------------------------------------------------------------------
// Command interpreter
// ----------------------------------------------------------------------------
module mmci_top (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  // Mailbox pins
  input  wire logic        i_sel_n,
  input  wire logic        i_register_select_line,
  input  wire logic        i_strobe_n,
  input  wire logic        i_read,
  input  wire logic [7:0]  i_data,
  output logic [7:0]       o_data,
  output logic             o_data_oe,
  output logic             o_mailbox_request_line_n,
  // Transmit bit stream
  input  wire logic        i_bit_en,
  input  wire logic        i_baud_en,
  output logic             o_tx_bit,
  output logic             o_tx_bit_valid,
  // Received data and status from the signal path
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_byte,
  input  wire logic [1:0]  i_phase,
  input  wire logic        i_band_one_det,
  input  wire logic        i_band_two_det,
  input  wire logic        i_answer_tone_det,
  input  wire logic        i_line_bad,
  input  wire logic        i_seg_timeout,
  input  wire logic        i_rate_illegal,
  input  wire logic [7:0]  i_rate_seq,
  input  wire logic [7:0]  i_train_events,
  input  wire logic [1:0]  i_line_quality,
  input  wire logic        i_remote_retrain,
  input  wire logic        i_hshk_done,
  input  wire logic        i_req_107,
  // Engine memory
  output logic [15:0]      o_mem_addr,
  output logic             o_mem_we,
  output logic [15:0]      o_mem_wdata,
  input  wire logic [15:0] i_mem_rdata,
  // Front end
  output logic [15:0]      o_fe_cfg,
  output logic             o_fe_cfg_stb,
  output logic [15:0]      o_front_end_xmit_reg_one,
  output logic [15:0]      o_front_end_xmit_reg_two,
  input  wire logic [11:0] i_front_end_read_reg_one,
  input  wire logic [11:0] i_front_end_read_reg_two,
  // Modem control
  output logic [15:0]      o_gain,
  output logic [15:0]      o_v32_cfg,
  output logic [15:0]      o_fsk_cfg,
  output logic [15:0]      o_v22_cfg,
  output logic             o_retrain_stb,
  output logic             o_hshk_active,
  // Tone generators
  output logic [7:0]       o_tone_sel,
  output logic             o_tone_sel_stb,
  output logic [15:0]      o_gen_one_inc,
  output logic [15:0]      o_gen_two_inc,
  output logic [1:0]       o_gen_en,
  output logic             o_gen_two_boost
);
  typedef struct packed {
    mmci_pkg::mmci_state_t st;
    logic [2:0]  strb_s, sel_s, rs_s, rd_s;
    logic [7:0]  din_s1, din_s2;
    logic [23:0] cmd, resp;
    logic [1:0]  wr_idx, rd_idx;
    logic [7:0]  dout;
    logic        req;
    logic [15:0] ptr, wdata;
    logic        we, rd_sel;
    logic        ans_pend, more;
    logic [15:0] ans;
    logic        rx_pend;
    logic [7:0]  rx_byte;
    logic [15:0] gain, v32, fsk, v22, fe_cfg, xr1, xr2, inc1, inc2;
    logic        fe_stb, tone_stb, retrain_stb, hshk;
    logic [7:0]  tone_sel;
    logic [1:0]  gen_en;
    logic        push;
    logic [7:0]  push_data;
    logic [7:0]  shift;
    logic [3:0]  bits;
  } mmci_top_t;
  mmci_top_t r_reg, r_next;

  logic       push_ready, pop_valid, pop_ready, strobe, ack, done_rd;
  logic [7:0] pop_data, op, b1, b2, st0;
  logic [3:0] flags;

  // Transmit FIFO between decoder and bit serialiser
  mmci_fifo #(.W(8), .D(16)) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (r_reg.push),
    .i_in_data   (r_reg.push_data),
    .o_in_ready  (push_ready),
    .o_out_valid (pop_valid),
    .o_out_data  (pop_data),
    .i_out_ready (pop_ready)
  );

  // Strobe edge seen on synchronised pins (stage 0 feeds stage 1 only)
  assign strobe  = r_reg.strb_s[2] && !r_reg.strb_s[1] && !r_reg.sel_s[1];
  assign ack     = strobe && r_reg.rd_s[1] && !r_reg.rs_s[1];
  assign done_rd = strobe && r_reg.rd_s[1] && r_reg.rs_s[1];
  assign op      = r_reg.cmd[7:0];
  assign b1      = r_reg.cmd[15:8];
  assign b2      = r_reg.cmd[23:16];
  assign pop_ready = (r_reg.bits == 4'h0);

  // Condition flags by phase, index 0 is condition_flag_zero
  always_comb begin
    flags = 4'h0;
    case (i_phase)
      mmci_pkg::MMCI_PH_CALL: begin
        flags = {1'b0, i_answer_tone_det, i_band_two_det, i_band_one_det};  // [R21]
      end
      mmci_pkg::MMCI_PH_HSHK: begin
        if (i_rate_illegal) flags[1:0] = 2'h3;  // [R22]
        else flags[1:0] = {i_seg_timeout, i_line_bad};  // [R22]
      end
      mmci_pkg::MMCI_PH_DATA: begin
        flags[1:0] = i_remote_retrain ? 2'h3 : i_line_quality;  // [R25]
      end
      default: flags = 4'h0;
    endcase
    st0 = 8'h00;
    st0[`MMCI_ST_FLAG_LSB +: 4] = flags;  // [R18]
    st0[`MMCI_ST_HSHK]   = r_reg.hshk;
    st0[`MMCI_ST_REQ107] = i_req_107;
  end

  // Next state
  always_comb begin
    r_next = r_reg;
    r_next.strb_s = {r_reg.strb_s[1:0], i_strobe_n};
    r_next.sel_s  = {r_reg.sel_s[1:0], i_sel_n};
    r_next.rs_s   = {r_reg.rs_s[1:0], i_register_select_line};
    r_next.rd_s   = {r_reg.rd_s[1:0], i_read};
    r_next.din_s1 = i_data;
    r_next.din_s2 = r_reg.din_s1;
    r_next.we = 1'b0;
    r_next.fe_stb = 1'b0;
    r_next.tone_stb = 1'b0;
    r_next.retrain_stb = 1'b0;
    r_next.push = r_reg.push && !push_ready;
    // Received data is held until it goes out in a response
    if (i_rx_valid) begin
      r_next.rx_pend = 1'b1;
      r_next.rx_byte = i_rx_byte;
    end
    if (i_hshk_done) r_next.hshk = 1'b0;  // [R24]
    // Serialiser, least significant bit first
    if (pop_valid && pop_ready) begin
      r_next.shift = pop_data;
      r_next.bits  = 4'h8;
    end else if (i_bit_en && r_reg.bits != 4'h0) begin
      r_next.shift = {1'b0, r_reg.shift[7:1]};  // [R5]
      r_next.bits  = r_reg.bits - 4'h1;
    end
    case (r_reg.st)
      mmci_pkg::MMCI_ST_XFER: begin
        if (strobe && !r_reg.rd_s[1]) begin
          r_next.cmd[r_reg.wr_idx*8 +: 8] = r_reg.din_s2;
          r_next.wr_idx = (r_reg.wr_idx == 2'h2) ? 2'h0 : r_reg.wr_idx + 2'h1;
        end else if (done_rd) begin
          r_next.st = mmci_pkg::MMCI_ST_EXEC;  // [R23]
        end else if (strobe && r_reg.rd_s[1]) begin
          r_next.rd_idx = (r_reg.rd_idx == 2'h2) ? 2'h0 : r_reg.rd_idx + 2'h1;
        end
      end
      mmci_pkg::MMCI_ST_EXEC: begin
        r_next.st = mmci_pkg::MMCI_ST_RESP;
        case (op)
          `MMCI_OP_INIT: begin
            if ({b2, b1} == `MMCI_INIT_ARG) begin
              r_next.gain = `MMCI_GAIN_RST;  // [R1]
              r_next.v32 = `MMCI_CFG_RST;
              r_next.fsk = `MMCI_CFG_RST;
              r_next.v22 = `MMCI_CFG_RST;
              r_next.xr1 = `MMCI_CFG_RST;
              r_next.xr2 = `MMCI_CFG_RST;
              r_next.inc1 = `MMCI_CFG_RST;
              r_next.inc2 = `MMCI_CFG_RST;
              r_next.gen_en = 2'h0;
              r_next.hshk = 1'b0;
              r_next.ans_pend = 1'b0;
            end
          end
          `MMCI_OP_HSHK:    r_next.hshk = 1'b1;  // [R24]
          `MMCI_OP_RETRAIN: r_next.retrain_stb = 1'b1;  // [R3]
          `MMCI_OP_SET_GAIN: r_next.gain = {b2, b1};  // [R4]
          `MMCI_OP_XMIT, `MMCI_OP_XMIT_MORE: begin
            if (r_reg.push) begin
              r_next.st = mmci_pkg::MMCI_ST_EXEC;  // Stall while FIFO is full
            end else begin
              r_next.push = 1'b1;  // [R5]
              r_next.push_data = b1;
              r_next.more = (op == `MMCI_OP_XMIT_MORE);  // [R6]
            end
          end
          `MMCI_OP_STORE, `MMCI_OP_STORE_CNT: begin
            r_next.we = 1'b1;  // [R7]
            r_next.wdata = {b2, b1};
          end
          `MMCI_OP_PTR_RD, `MMCI_OP_PTR_RD_PAIR: begin
            r_next.ptr = {b2, b1};  // [R8] [R9]
            r_next.rd_sel = 1'b0;
            r_next.st = mmci_pkg::MMCI_ST_RDA;
          end
          `MMCI_OP_V32_CFG: r_next.v32 = {b2, b1};  // [R10]
          `MMCI_OP_FSK_CFG: r_next.fsk = {b2, b1};  // [R10]
          `MMCI_OP_V22_CFG: r_next.v22 = {b2, b1};  // [R10]
          `MMCI_OP_FE_CFG: begin
            r_next.fe_cfg = {b2, b1};  // [R11]
            r_next.fe_stb = 1'b1;
          end
          `MMCI_OP_FE_RD_ONE: begin
            r_next.ans = {4'h0, i_front_end_read_reg_one};  // [R12]
            r_next.ans_pend = 1'b1;
          end
          `MMCI_OP_FE_RD_TWO: begin
            r_next.ans = {4'h0, i_front_end_read_reg_two};  // [R12]
            r_next.ans_pend = 1'b1;
          end
          `MMCI_OP_FE_WR_ONE: r_next.xr1 = {b2, b1};  // [R12]
          `MMCI_OP_FE_WR_TWO: r_next.xr2 = {b2, b1};  // [R12]
          `MMCI_OP_TONE_SEL: begin
            r_next.tone_sel = b1;  // [R13]
            r_next.tone_stb = 1'b1;
          end
          `MMCI_OP_DEF_GEN_ONE: r_next.inc1 = {b2, b1};  // [R14]
          `MMCI_OP_DEF_GEN_TWO: r_next.inc2 = {b2, b1};  // [R14]
          `MMCI_OP_TONE_CTL: begin
            // Silence is the argument 00, which clears both enables
            r_next.gen_en = b1[1:0];  // [R15] [R16]
          end
          default: r_next.st = mmci_pkg::MMCI_ST_RESP;  // [R2] [R26]
        endcase
      end
      mmci_pkg::MMCI_ST_RDA: begin
        if (op == `MMCI_OP_PTR_RD_PAIR) begin
          r_next.ans[7:0] = i_mem_rdata[15:8];  // [R9]
          r_next.rd_sel = 1'b1;
          r_next.st = mmci_pkg::MMCI_ST_RDB;
        end else begin
          r_next.ans = i_mem_rdata;  // [R8]
          r_next.ans_pend = 1'b1;
          r_next.st = mmci_pkg::MMCI_ST_RESP;
        end
      end
      mmci_pkg::MMCI_ST_RDB: begin
        r_next.ans[15:8] = i_mem_rdata[15:8];  // [R9]
        r_next.ans_pend = 1'b1;
        r_next.rd_sel = 1'b0;
        r_next.st = mmci_pkg::MMCI_ST_RESP;
      end
      mmci_pkg::MMCI_ST_RESP: begin
        if (op == `MMCI_OP_STORE_CNT && r_reg.we) r_next.ptr = r_reg.ptr + 16'h1;  // [R7]
        if (!r_reg.more || i_baud_en) begin
          r_next.more = 1'b0;  // [R6]
          r_next.st = mmci_pkg::MMCI_ST_HOST;
          r_next.req = 1'b1;  // [R17]
          r_next.rd_idx = 2'h0;
          r_next.resp[7:0] = st0;
          if (r_reg.rx_pend) begin
            // Data goes before any answer
            r_next.resp[7:0] = st0 | (8'h1 << `MMCI_ST_INFO_B);  // [R17] [R19]
            r_next.resp[23:8] = {i_train_events, r_reg.rx_byte};
            r_next.rx_pend = i_rx_valid;
          end else if (r_reg.ans_pend) begin
            r_next.resp[7:0] = st0 | (8'h1 << `MMCI_ST_INFO_A)
                             | (8'h1 << `MMCI_ST_INFO_B);  // [R19]
            r_next.resp[23:8] = r_reg.ans;
            r_next.ans_pend = 1'b0;
          end else begin
            r_next.resp[7:0] = st0 | (8'h1 << `MMCI_ST_INFO_A);  // [R19]
            r_next.resp[23:8] = {i_train_events, i_rate_seq};  // [R20]
          end
        end
      end
      mmci_pkg::MMCI_ST_HOST: begin
        if (ack) begin
          r_next.req = 1'b0;  // [R23]
          r_next.wr_idx = 2'h0;
          r_next.rd_idx = 2'h0;
          r_next.st = mmci_pkg::MMCI_ST_XFER;
        end
      end
      default: r_next.st = mmci_pkg::MMCI_ST_XFER;
    endcase
    r_next.dout = r_next.resp[r_next.rd_idx*8 +: 8];
  end

  // State register; the host owns the mailbox after reset
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r_reg <= '0;
      r_reg.st <= mmci_pkg::MMCI_ST_XFER;
      r_reg.strb_s <= 3'h7;
      r_reg.sel_s <= 3'h7;
      r_reg.gain <= `MMCI_GAIN_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs
  assign o_data = r_reg.dout;
  assign o_data_oe = !i_sel_n && i_read && !i_strobe_n && r_reg.st[0];
  assign o_mailbox_request_line_n = !r_reg.req;
  assign o_tx_bit = r_reg.shift[0];
  assign o_tx_bit_valid = (r_reg.bits != 4'h0);
  assign o_mem_addr = r_reg.ptr + {15'h0, r_reg.rd_sel};
  assign o_mem_we = r_reg.we;
  assign o_mem_wdata = r_reg.wdata;
  assign o_fe_cfg = r_reg.fe_cfg;
  assign o_fe_cfg_stb = r_reg.fe_stb;
  assign o_front_end_xmit_reg_one = r_reg.xr1;
  assign o_front_end_xmit_reg_two = r_reg.xr2;
  assign o_gain = r_reg.gain;
  assign o_v32_cfg = r_reg.v32;
  assign o_fsk_cfg = r_reg.fsk;
  assign o_v22_cfg = r_reg.v22;
  assign o_retrain_stb = r_reg.retrain_stb;
  assign o_hshk_active = r_reg.hshk;
  assign o_tone_sel = r_reg.tone_sel;
  assign o_tone_sel_stb = r_reg.tone_stb;
  assign o_gen_one_inc = r_reg.inc1;
  assign o_gen_two_inc = r_reg.inc2;
  assign o_gen_en = r_reg.gen_en;
  assign o_gen_two_boost = (r_reg.gen_en == 2'h3);  // [R16]

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  localparam int DROP_MAX = `MMCI_REQ_DROP_CYC;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  a_req_drop_ack: assert property (ack && r_reg.req |-> ##[1:DROP_MAX] !r_reg.req)  // [R23]
    else $error("Request not dropped after acknowledge");
  a_gain_load: assert property (r_reg.st[1] && op == `MMCI_OP_SET_GAIN  // [R4]
      |=> o_gain == $past(r_reg.cmd[23:8]))
    else $error("Gain not loaded from bytes 1 and 2");
  a_init_defaults: assert property (r_reg.st[1] && op == `MMCI_OP_INIT  // [R1]
      && r_reg.cmd[23:8] == `MMCI_INIT_ARG |=> o_gain == `MMCI_GAIN_RST && o_gen_en == 2'h0)
    else $error("Defaults not restored");
  a_store_count: assert property (r_reg.st[1] && op == `MMCI_OP_STORE_CNT  // [R7]
      |=> o_mem_we ##1 o_mem_addr == $past(o_mem_addr, 2) + 16'h1)
    else $error("Pointer not incremented after store");
  a_store_keep: assert property (r_reg.st[1] && op == `MMCI_OP_STORE  // [R7]
      |=> o_mem_we ##1 $stable(o_mem_addr))
    else $error("Plain store moved the pointer");
  a_tone_define: assert property (r_reg.st[1] && op == `MMCI_OP_DEF_GEN_ONE  // [R14]
      |=> $stable(o_gen_en) && o_gen_one_inc == $past(r_reg.cmd[23:8]))
    else $error("Define-tone changed enables or missed increment");
  a_silence_off: assert property (r_reg.st[1] && r_reg.cmd == 24'h00000d |=> o_gen_en == 2'h0)  // [R15]
    else $error("Silence left a generator on");
  a_answer_type: assert property (r_reg.st[4] && r_reg.ans_pend && !r_reg.rx_pend  // [R19]
      && !r_reg.more |=> r_reg.resp[`MMCI_ST_INFO_A] && r_reg.resp[`MMCI_ST_INFO_B])
    else $error("Answer posted with wrong info type");
  a_data_first: assert property (r_reg.st[4] && r_reg.rx_pend && !r_reg.more  // [R17]
      |=> r_reg.resp[15:8] == $past(r_reg.rx_byte) && !r_reg.resp[`MMCI_ST_INFO_A])
    else $error("Data not sent ahead of answer");
  a_hshk_hold: assert property (r_reg.hshk && !i_hshk_done && !r_reg.st[1] |=> r_reg.hshk)  // [R24]
    else $error("Handshake bit dropped early");

  c_exchange: cover property (ack ##[1:200] done_rd);
  c_pair_read: cover property (r_reg.st[2] ##1 r_reg.st[3]);
  c_fifo_full: cover property (!push_ready);
endmodule

// ==== common/mmci_cfg.svh ====
// Constants of the mailbox command interpreter: opcodes, field positions,
// reset values and timing counts.
// Assumes inclusion by package and design files alike.
`ifndef MMCI_CFG_SVH
`define MMCI_CFG_SVH

// --------------------------------------------------------------------------
// Opcodes (byte 0), with the argument values of the reset-defaults and silence commands
// --------------------------------------------------------------------------
`define MMCI_OP_IDLE        8'h00
`define MMCI_OP_XMIT_MORE   8'h01
`define MMCI_OP_SET_GAIN    8'h02
`define MMCI_OP_XMIT        8'h03
`define MMCI_OP_HSHK        8'h04
`define MMCI_OP_RETRAIN     8'h05
`define MMCI_OP_INIT        8'h06
`define MMCI_OP_FE_CFG      8'h07
`define MMCI_OP_FE_RD_ONE   8'h08
`define MMCI_OP_FE_RD_TWO   8'h09
`define MMCI_OP_FE_WR_ONE   8'h0a
`define MMCI_OP_FE_WR_TWO   8'h0b
`define MMCI_OP_TONE_SEL    8'h0c
`define MMCI_OP_TONE_CTL    8'h0d
`define MMCI_OP_DEF_GEN_ONE 8'h0e
`define MMCI_OP_DEF_GEN_TWO 8'h0f
`define MMCI_OP_PTR_RD      8'h10
`define MMCI_OP_PTR_RD_PAIR 8'h11
`define MMCI_OP_STORE       8'h12
`define MMCI_OP_STORE_CNT   8'h13
`define MMCI_OP_FSK_CFG     8'h1d
`define MMCI_OP_V22_CFG     8'h1e
`define MMCI_OP_V32_CFG     8'h20
`define MMCI_INIT_ARG       16'hc000
`define MMCI_SILENCE_ARG    8'h00

// --------------------------------------------------------------------------
// Status byte 0 layout
// --------------------------------------------------------------------------
`define MMCI_ST_FLAG_LSB    4
`define MMCI_ST_INFO_A      3
`define MMCI_ST_INFO_B      2
`define MMCI_ST_HSHK        1
`define MMCI_ST_REQ107      0

// --------------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------------
`define MMCI_GAIN_RST       16'h0100
`define MMCI_CFG_RST        16'h0000

// --------------------------------------------------------------------------
// Timing: request must drop within this time of the acknowledge read
// --------------------------------------------------------------------------
`define MMCI_CLK_NS         50
`define MMCI_REQ_DROP_NS    800
`define MMCI_REQ_DROP_CYC   (`MMCI_REQ_DROP_NS / `MMCI_CLK_NS)

`endif

// ==== common/mmci_pkg.sv ====
// Types of the mailbox command interpreter.
// Assumes mmci_cfg.svh is on the include path.
package mmci_pkg;
  // Engine states, one-hot
  typedef enum logic [5:0] {
    MMCI_ST_XFER = 6'h01,  // Host owns the mailbox
    MMCI_ST_EXEC = 6'h02,  // Decode and execute
    MMCI_ST_RDA  = 6'h04,  // Capture addressed word
    MMCI_ST_RDB  = 6'h08,  // Capture next word
    MMCI_ST_RESP = 6'h10,  // Build response
    MMCI_ST_HOST = 6'h20   // Request raised, waiting for acknowledge
  } mmci_state_t;

  // Operating phase reported by the signal path
  typedef enum logic [1:0] {
    MMCI_PH_CALL = 2'h0,
    MMCI_PH_HSHK = 2'h1,
    MMCI_PH_DATA = 2'h2
  } mmci_phase_t;
endpackage

// ==== sim/mmci_host.sv ====
// Host model: byte-wide mailbox master, one command exchange per xfer call.
// Assumes the engine answers reads from o_data on the same clock.
module mmci_host (
  // Clock and request
  input  wire logic       i_ref_clk,
  input  wire logic       i_req_n,
  input  wire logic [7:0] i_rd,
  // Mailbox pins
  output logic            o_sel_n,
  output logic            o_rs,
  output logic            o_stb_n,
  output logic            o_read,
  output logic [7:0]      o_wd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic own  = 1'b1;
  logic late = 1'b0;
  initial {o_sel_n, o_rs, o_stb_n, o_read, o_wd} = 12'hb00;
  // One access, strobe low four cycles; a released data pin shows its inverse
  task automatic acc(input logic rd, input logic rs, input logic [7:0] d, output logic [7:0] q);
    @(posedge i_ref_clk);
    #5;
    {o_read, o_rs, o_sel_n, o_stb_n} = {rd, rs, 2'b00};
    o_wd = rd ? ~o_wd : d;
    q = i_rd;
    repeat (4) @(posedge i_ref_clk);
    #5;
    o_stb_n = 1'b1;
    repeat (3) @(posedge i_ref_clk);
  endtask
  // Acknowledge, three writes, three reads, closing read
  task automatic xfer(input logic [23:0] c, output logic [7:0] r [3]);
    logic [7:0] q;
    int         n;
    n = 0;
    while (!own && i_req_n !== 1'b0 && n < 400) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (!own) acc(1'b1, 1'b0, 8'h00, q);
    if (!own && (n == 400 || i_req_n !== 1'b1)) late = 1'b1;
    for (int i = 0; i < 3; i++) acc(1'b0, 1'b0, c[23-8*i -: 8], q);
    for (int i = 0; i < 3; i++) acc(1'b1, 1'b0, 8'h00, r[i]);
    acc(1'b1, 1'b1, 8'h00, q);
    own = 1'b0;
  endtask
endmodule

// ==== sim/tb.sv ====
// Bench: command table, then memory, priority, flag, transmit and retrain cases.
// Assumes mmci_host drives the mailbox; memory returns the inverted address.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_ref_clk = 1'b0, i_reset_n = 1'b0, bit_en = 1'b0, rx_v = 1'b0, rt = 1'b0;
  logic [7:0]  rx_b = 8'h00, r [3], tx;
  logic [31:0] st = 32'h0, sv [3] = '{32'ha014, 32'h6081, 32'h4202};
  logic [15:0] w_a, w_d;
  int          num_errors = 0, samples_checked = 0, cyc = 0;
  wire         sel_n, rs, stb_n, rd, req_n, we, txb, txv, rtr, boost, hshk;
  wire [7:0]   hd, od, tsel;
  wire [1:0]   gen_en;
  wire [15:0]  addr, wd, q [11];
  logic [47:0] rows [18] = '{48'h023412001234, 48'h000000001234, 48'h3f0000001234,
    48'h201122012211, 48'h1d3344024433, 48'h1e5566036655, 48'h07a05b045ba0,
    48'h0a2103050321, 48'h0b4305060543, 48'h0ecdab07abcd, 48'h0f01ef08ef01,
    48'h0c10000a0010, 48'h0c1000090000, 48'h0d0300090007, 48'h0d0000090000,
    48'h040000090008, 48'h0600c0000100, 48'h0600c0010000};
  assign q[9] = {12'h000, hshk, boost, gen_en};
  assign q[10] = {8'h00, tsel};
  mmci_host u_mmci_host (.i_ref_clk, .i_req_n(req_n), .i_rd(od), .o_sel_n(sel_n), .o_rs(rs),
    .o_stb_n(stb_n), .o_read(rd), .o_wd(hd));
  mmci_top u_mmci_top (.i_ref_clk, .i_reset_n, .i_sel_n(sel_n), .i_register_select_line(rs),
    .i_strobe_n(stb_n), .i_read(rd), .i_data(hd), .o_data(od), .o_data_oe(),
    .o_mailbox_request_line_n(req_n), .i_bit_en(bit_en), .i_baud_en(bit_en), .o_tx_bit(txb),
    .o_tx_bit_valid(txv), .i_rx_valid(rx_v), .i_rx_byte(rx_b), .i_phase(st[1:0]),
    .i_band_one_det(st[2]), .i_band_two_det(st[3]), .i_answer_tone_det(st[4]),
    .i_line_bad(st[5]), .i_seg_timeout(st[6]), .i_rate_illegal(st[7]),
    .i_rate_seq(st[23:16]), .i_train_events(st[31:24]), .i_line_quality(st[9:8]),
    .i_remote_retrain(st[10]), .i_hshk_done(st[12]), .i_req_107(st[11]),
    .o_mem_addr(addr), .o_mem_we(we), .o_mem_wdata(wd), .i_mem_rdata(~addr),
    .o_fe_cfg(q[4]), .o_fe_cfg_stb(), .o_front_end_xmit_reg_one(q[5]),
    .o_front_end_xmit_reg_two(q[6]), .i_front_end_read_reg_one(12'h5a3),
    .i_front_end_read_reg_two(12'ha5c), .o_gain(q[0]), .o_v32_cfg(q[1]), .o_fsk_cfg(q[2]),
    .o_v22_cfg(q[3]), .o_retrain_stb(rtr), .o_hshk_active(hshk), .o_tone_sel(tsel),
    .o_tone_sel_stb(), .o_gen_one_inc(q[7]), .o_gen_two_inc(q[8]), .o_gen_en(gen_en),
    .o_gen_two_boost(boost));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [23:0] c);
    u_mmci_host.xfer(c, r);
    #5;
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Clock, cycle ceiling, memory write and retrain capture
  always #25 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (we) {w_a, w_d} <= {addr, wd};
    if (rtr) rt <= 1'b1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge i_ref_clk);
    #5 i_reset_n = 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #5 chk("gain reset", 16'h0100, q[0]);
    for (int i = 0; i < 18; i++) begin
      cmd(rows[i][47:24]);
      chk("table", rows[i][15:0], q[rows[i][23:16]]);
    end
    $display("table done");
    cmd(24'h100020);
    cmd(24'h12aa55);
    chk("ptr word", 16'hdfff, {r[2], r[1]});
    chk("wr addr", 16'h2000, w_a);
    chk("wr data", 16'h55aa, w_d);
    cmd(24'h131122);
    chk("count ptr", 16'h2001, addr);
    cmd(24'h11ff30);
    cmd(24'h080000);
    chk("pair", 16'hcecf, {r[2], r[1]});
    chk("pair ptr", 16'h30ff, addr);
    cmd(24'h000000);
    chk("fe read", 16'h05a3, {r[2], r[1]});
    rx_b = 8'h5e;
    rx_v = 1'b1;
    #50 rx_v = 1'b0;
    cmd(24'h100040);
    cmd(24'h000000);
    chk("data first", 16'h015e, {6'h00, r[0][3:2], r[1]});
    cmd(24'h000000);
    chk("answer next", 16'h03bf, {6'h00, r[0][3:2], r[2]});
    $display("memory and priority done");
    for (int i = 0; i < 3; i++) begin
      st = sv[i];
      cmd(24'h000000);
      cmd(24'h000000);
      chk("flags", {13'h0, sv[i][15:13]}, {12'h0, r[0][7:4]});
    end
    st = 32'h0;
    cmd(24'h0396ff);
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 50 && txv !== 1'b1; k++) #50;
      tx[i] = txb;
      bit_en = 1'b1;
      #50 bit_en = 1'b0;
    end
    chk("tx byte", 16'h0096, {8'h00, tx});
    cmd(24'h01a500);
    chk("more wait", 16'h0001, {15'h0, req_n});
    bit_en = 1'b1;
    #50 bit_en = 1'b0;
    cmd(24'h050000);
    chk("retrain", 16'h0001, {15'h0, rt});
    chk("req late", 16'h0000, {15'h0, u_mmci_host.late});
    $display("flags transmit retrain done");
    report_and_stop();
  end
endmodule
